//--- src/crypto_engine_control.sv
/*
 * Control front end of the crypto engine: control register, run sequencing, events and interrupt.
 * Assumes a cipher datapath that takes start and abort pulses and reports done, consumed and wrap.
 */
`timescale 1ns/1ns
`include "crypto_engine_control_params.svh"
module crypto_engine_control #(
	parameter int OPSEL_W   = 4,
	parameter int VARIANT_W = 3
) (
	input  wire logic                                   clock,
	input  wire logic                                   nrst,
	input  wire logic [7:0]                             regAddr,
	input  wire logic [15:0]                            regWriteData,
	input  wire logic                                   regWrite,
	input  wire logic                                   regRead,
	output logic      [15:0]                            regReadData,
	input  wire logic                                   idleMode,
	input  wire logic                                   opDone,
	input  wire logic                                   inputConsumed,
	input  wire logic                                   counterWrap,
	output logic                                        engineOn,
	output logic                                        engineActive,
	output logic                                        opStart,
	output logic                                        opAbort,
	output logic      [OPSEL_W-1:0]                     operationSelect,
	output logic                                        cipherSelect,
	output logic      [VARIANT_W-1:0]                   cipherVariant,
	output crypto_engine_control_pkg::abort_cause_t     lastAbortCause,
	output logic                                        eventPulse,
	output logic                                        irq
);
	import crypto_engine_control_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Register port decode.

	function automatic logic writeHit(input logic [7:0] offset);
		writeHit = regWrite && (regAddr == offset);
	endfunction : writeHit

	logic ctrlWrite;
	logic modeWrite;
	logic irqClearWrite;
	logic irqEnableWrite;

	assign ctrlWrite      = writeHit(`CTRL_OFFSET);
	assign modeWrite      = writeHit(`MODE_OFFSET);
	assign irqClearWrite  = writeHit(`IRQ_CLEAR_OFFSET);
	assign irqEnableWrite = writeHit(`IRQ_ENABLE_OFFSET);

	////////////////////////////////////////////////////////////////////////////////
	// Control register fields.

	logic                 enable_ff;
	logic                 nxt_enable;
	logic                 stopInIdle_ff;
	logic                 nxt_stopInIdle;
	logic                 wrapIe_ff;
	logic                 nxt_wrapIe;
	logic                 finishIe_ff;
	logic                 nxt_finishIe;
	logic                 consumedIe_ff;
	logic                 nxt_consumedIe;
	logic                 go_ff;
	logic                 nxt_go;
	logic [OPSEL_W-1:0]   opSel_ff;
	logic [OPSEL_W-1:0]   nxt_opSel;
	logic                 cipherSel_ff;
	logic                 nxt_cipherSel;
	logic [VARIANT_W-1:0] variant_ff;
	logic [VARIANT_W-1:0] nxt_variant;
	logic                 clearMode_ff;
	logic                 nxt_clearMode;

	logic                 halted;
	logic                 runEnd;
	logic                 runAbort;

	assign halted = idleMode && stopInIdle_ff;

	always_comb begin
		nxt_enable     = enable_ff;
		nxt_stopInIdle = stopInIdle_ff;
		nxt_wrapIe     = wrapIe_ff;
		nxt_finishIe   = finishIe_ff;
		nxt_consumedIe = consumedIe_ff;
		nxt_go         = go_ff;
		nxt_opSel      = opSel_ff;
		nxt_cipherSel  = cipherSel_ff;
		nxt_variant    = variant_ff;
		nxt_clearMode  = clearMode_ff;
		if (modeWrite) begin
			nxt_clearMode = regWriteData[`BIT_MODE_CLEAR];
		end
		if (ctrlWrite) begin
			nxt_enable     = regWriteData[`BIT_ENABLE];
			nxt_stopInIdle = regWriteData[`BIT_STOP_IDLE];
			nxt_wrapIe     = regWriteData[`BIT_WRAP_IE];
			nxt_finishIe   = regWriteData[`BIT_FINISH_IE];
			nxt_consumedIe = regWriteData[`BIT_CONSUMED_IE];
			nxt_go         = regWriteData[`BIT_GO];
			if (!go_ff) begin
				nxt_opSel     = regWriteData[`BIT_OPSEL_LO +: OPSEL_W];
				nxt_cipherSel = regWriteData[`BIT_CIPHER_SEL];
				nxt_variant   = regWriteData[`BIT_VARIANT_LO +: VARIANT_W];
			end
		end
		// Ending a run always drops go, even against a software write of one in that cycle.
		if (runEnd || runAbort) begin
			nxt_go = 1'b0;
		end
		if (clearMode_ff) begin
			nxt_wrapIe     = 1'b0;
			nxt_finishIe   = 1'b0;
			nxt_consumedIe = 1'b0;
			nxt_go         = 1'b0;
			nxt_opSel      = '0;
			nxt_cipherSel  = 1'b0;
			nxt_variant    = '0;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			enable_ff     <= 1'b0;
			stopInIdle_ff <= 1'b0;
			wrapIe_ff     <= 1'b0;
			finishIe_ff   <= 1'b0;
			consumedIe_ff <= 1'b0;
			go_ff         <= 1'b0;
			opSel_ff      <= '0;
			cipherSel_ff  <= 1'b0;
			variant_ff    <= '0;
			clearMode_ff  <= 1'b0;
		end else begin
			enable_ff     <= nxt_enable;
			stopInIdle_ff <= nxt_stopInIdle;
			wrapIe_ff     <= nxt_wrapIe;
			finishIe_ff   <= nxt_finishIe;
			consumedIe_ff <= nxt_consumedIe;
			go_ff         <= nxt_go;
			opSel_ff      <= nxt_opSel;
			cipherSel_ff  <= nxt_cipherSel;
			variant_ff    <= nxt_variant;
			clearMode_ff  <= nxt_clearMode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Run sequencer.

	run_state_t   state_ff;
	run_state_t   nxt_state;
	abort_cause_t abortCause_ff;
	abort_cause_t nxt_abortCause;
	logic         opStart_ff;
	logic         nxt_opStart;
	logic         opAbort_ff;
	logic         nxt_opAbort;
	logic         runStart;

	// A go left set while disabled or halted simply waits; it starts once both clear.
	assign runStart = (state_ff == stIdle) && go_ff && enable_ff && !halted && !clearMode_ff;

	// Abort is checked before done, so a stop that races a completion counts as a stop.
	assign runAbort = (state_ff == stRun) && (!go_ff || halted || !enable_ff || clearMode_ff);
	assign runEnd   = (state_ff == stRun) && !runAbort && opDone;

	always_comb begin
		nxt_state      = state_ff;
		nxt_abortCause = abortCause_ff;
		nxt_opStart    = 1'b0;
		nxt_opAbort    = 1'b0;
		case (state_ff)
			stIdle: begin
				if (runStart) begin
					nxt_state   = stRun;
					nxt_opStart = 1'b1;
				end
			end
			stRun: begin
				if (runAbort) begin
					nxt_state   = stIdle;
					nxt_opAbort = 1'b1;
					if (clearMode_ff) begin
						nxt_abortCause = abortClearMode;
					end else if (!enable_ff) begin
						nxt_abortCause = abortDisable;
					end else if (halted) begin
						nxt_abortCause = abortIdle;
					end else begin
						nxt_abortCause = abortSoftware;
					end
				end else if (runEnd) begin
					nxt_state = stIdle;
				end
			end
			default: begin
				nxt_state = stIdle;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_ff      <= stIdle;
			abortCause_ff <= abortSoftware;
			opStart_ff    <= 1'b0;
			opAbort_ff    <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			abortCause_ff <= nxt_abortCause;
			opStart_ff    <= nxt_opStart;
			opAbort_ff    <= nxt_opAbort;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operation statistics: completed count and length of the last run in clocks.

	logic [15:0] opCount_ff;
	logic [15:0] nxt_opCount;
	logic [15:0] runCycles_ff;
	logic [15:0] nxt_runCycles;
	logic [15:0] lastCycles_ff;
	logic [15:0] nxt_lastCycles;

	always_comb begin
		nxt_opCount    = opCount_ff;
		nxt_runCycles  = runCycles_ff;
		nxt_lastCycles = lastCycles_ff;
		if (runStart) begin
			nxt_runCycles = `WORD_ZERO;
		end else if (state_ff == stRun) begin
			// The counter saturates rather than wrap, so a very long run never reads as short.
			if (runCycles_ff != 16'hffff) begin
				nxt_runCycles = runCycles_ff + 16'h0001;
			end
			if (runEnd || runAbort) begin
				nxt_lastCycles = nxt_runCycles;
			end
		end
		if (runEnd) begin
			nxt_opCount = opCount_ff + 16'h0001;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			opCount_ff    <= `WORD_ZERO;
			runCycles_ff  <= `WORD_ZERO;
			lastCycles_ff <= `WORD_ZERO;
		end else begin
			opCount_ff    <= nxt_opCount;
			runCycles_ff  <= nxt_runCycles;
			lastCycles_ff <= nxt_lastCycles;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Events and interrupt.

	logic [`EVT_COUNT-1:0] events;
	logic [`EVT_COUNT-1:0] irqStatus;
	logic [`EVT_COUNT-1:0] irqEnable;
	logic                  eventPulse_ff;
	logic                  nxt_eventPulse;

	always_comb begin
		events                = '0;
		events[`EVT_WRAP]     = counterWrap && wrapIe_ff && enable_ff;
		events[`EVT_FINISH]   = runEnd && finishIe_ff;
		events[`EVT_CONSUMED] = (state_ff == stRun) && !runAbort && inputConsumed && consumedIe_ff;
		events[`EVT_ABORT]    = runAbort;
		nxt_eventPulse        = events[`EVT_WRAP] || events[`EVT_FINISH] || events[`EVT_CONSUMED];
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			eventPulse_ff <= 1'b0;
		end else begin
			eventPulse_ff <= nxt_eventPulse;
		end
	end

	irq_event_unit #(
		.WIDTH       (`EVT_COUNT)
	) irqUnit (
		.clock       (clock),
		.nrst        (nrst),
		.events      (events),
		.clearWrite  (irqClearWrite),
		.enableWrite (irqEnableWrite),
		.writeData   (regWriteData[`EVT_COUNT-1:0]),
		.status      (irqStatus),
		.enable      (irqEnable),
		.irq         (irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read side; unmapped and write-only offsets read zero.

	logic [15:0] readData_ff;
	logic [15:0] nxt_readData;
	logic [15:0] ctrlWord;

	always_comb begin
		ctrlWord                                     = `CTRL_RESET;
		ctrlWord[`BIT_ENABLE]                        = enable_ff;
		ctrlWord[`BIT_STOP_IDLE]                     = stopInIdle_ff;
		ctrlWord[`BIT_WRAP_IE]                       = wrapIe_ff;
		ctrlWord[`BIT_FINISH_IE]                     = finishIe_ff;
		ctrlWord[`BIT_CONSUMED_IE]                   = consumedIe_ff;
		ctrlWord[`BIT_GO]                            = go_ff;
		ctrlWord[`BIT_OPSEL_LO +: OPSEL_W]           = opSel_ff;
		ctrlWord[`BIT_CIPHER_SEL]                    = cipherSel_ff;
		ctrlWord[`BIT_VARIANT_LO +: VARIANT_W]       = variant_ff;
		nxt_readData = `WORD_ZERO;
		if (regRead) begin
			case (regAddr)
				`CTRL_OFFSET: begin
					nxt_readData = ctrlWord;
				end
				`STATUS_OFFSET: begin
					nxt_readData[0]   = (state_ff == stRun);
					nxt_readData[1]   = halted;
					nxt_readData[2]   = go_ff && (state_ff == stIdle);
					nxt_readData[5:4] = abortCause_ff;
				end
				`IRQ_STAT_OFFSET: begin
					nxt_readData[`EVT_COUNT-1:0] = irqStatus;
				end
				`IRQ_ENABLE_OFFSET: begin
					nxt_readData[`EVT_COUNT-1:0] = irqEnable;
				end
				`MODE_OFFSET: begin
					nxt_readData[`BIT_MODE_CLEAR] = clearMode_ff;
					nxt_readData[`BIT_MODE_BUSY]  = (state_ff == stRun);
				end
				`OP_COUNT_OFFSET: begin
					nxt_readData = opCount_ff;
				end
				`LAST_CYC_OFFSET: begin
					nxt_readData = lastCycles_ff;
				end
				default: begin
					nxt_readData = `WORD_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			readData_ff <= `WORD_ZERO;
		end else begin
			readData_ff <= nxt_readData;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign regReadData     = readData_ff;
	assign engineOn        = enable_ff;
	assign engineActive    = (state_ff == stRun);
	assign opStart         = opStart_ff;
	assign opAbort         = opAbort_ff;
	assign operationSelect = opSel_ff;
	assign cipherSelect    = cipherSel_ff;
	assign cipherVariant   = variant_ff;
	assign lastAbortCause  = abortCause_ff;
	assign eventPulse      = eventPulse_ff;

endmodule : crypto_engine_control

//--- src/crypto_engine_control_params.svh
/*
 * Register offsets, field positions and reset values of the crypto engine control front end.
 * Assumes an 8-bit byte address on the register port and 16-bit register data.
 */
// Overview of operation
// - The engine runs only while the enable bit, bit 15, is one.
// - With stop-in-idle set the engine halts in Idle; otherwise it keeps running.
// - Entering Idle with stop-in-idle set aborts the running operation.
// - Wrap enable set raises an event whenever the buffer counter wraps to zero while the enable bit is one.
// - Finish enable set raises an event as each operation completes.
// - Input-consumed enable set raises an event once the input text is consumed.
// - Writing one to go starts the selected operation; hardware clears go when done.
// - Software clearing go during an operation stops that operation at once.
// - While go is set, writes to operation and cipher fields are ignored.
// - Event enables, go, operation and cipher fields clear on reset or clear mode; the enable bit clears on reset only.
// - Control bits 14 and 9 read zero and ignore writes.
`ifndef CRYPTO_ENGINE_CONTROL_PARAMS_SVH
`define CRYPTO_ENGINE_CONTROL_PARAMS_SVH

`define CTRL_OFFSET       8'h00
`define STATUS_OFFSET     8'h04
`define IRQ_STAT_OFFSET   8'h08
`define IRQ_CLEAR_OFFSET  8'h0c
`define IRQ_ENABLE_OFFSET 8'h10
`define MODE_OFFSET       8'h14
`define OP_COUNT_OFFSET   8'h18
`define LAST_CYC_OFFSET   8'h1c

`define BIT_ENABLE        15
`define BIT_STOP_IDLE     13
`define BIT_WRAP_IE       12
`define BIT_FINISH_IE     11
`define BIT_CONSUMED_IE   10
`define BIT_GO            8
`define BIT_OPSEL_LO      4
`define BIT_CIPHER_SEL    3
`define BIT_VARIANT_LO    0

`define BIT_MODE_CLEAR    0
`define BIT_MODE_BUSY     1

`define EVT_WRAP          0
`define EVT_FINISH        1
`define EVT_CONSUMED      2
`define EVT_ABORT         3
`define EVT_COUNT         4

`define CTRL_RESET        16'h0000
`define WORD_ZERO         16'h0000

`endif

//--- src/crypto_engine_control_pkg.sv
/*
 * Types shared by the crypto engine control front end.
 * Assumes nothing of its surroundings.
 */
package crypto_engine_control_pkg;

	typedef enum logic {
		stIdle,
		stRun
	} run_state_t;

	typedef enum logic [1:0] {
		abortSoftware,
		abortIdle,
		abortDisable,
		abortClearMode
	} abort_cause_t;

endpackage : crypto_engine_control_pkg

//--- src/irq_event_unit.sv
/*
 * Sticky interrupt status with a write-only clear and an enable mask, one level output.
 * Assumes write strobes are one clock long and synchronous to clock.
 */
`timescale 1ns/1ns
module irq_event_unit #(
	parameter int WIDTH = 4
) (
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] events,
	input  wire logic             clearWrite,
	input  wire logic             enableWrite,
	input  wire logic [WIDTH-1:0] writeData,
	output logic      [WIDTH-1:0] status,
	output logic      [WIDTH-1:0] enable,
	output logic                  irq
);

	logic [WIDTH-1:0] status_ff;
	logic [WIDTH-1:0] nxt_status;
	logic [WIDTH-1:0] enable_ff;
	logic [WIDTH-1:0] nxt_enable;

	////////////////////////////////////////////////////////////////////////////////
	// A new event outranks a clear in the same cycle so no event is ever lost.
	always_comb begin
		nxt_status = status_ff;
		nxt_enable = enable_ff;
		if (clearWrite) begin
			nxt_status = status_ff & ~writeData;
		end
		nxt_status = nxt_status | events;
		if (enableWrite) begin
			nxt_enable = writeData;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			status_ff <= '0;
			enable_ff <= '0;
		end else begin
			status_ff <= nxt_status;
			enable_ff <= nxt_enable;
		end
	end

	assign status = status_ff;
	assign enable = enable_ff;
	assign irq    = |(status_ff & enable_ff);

endmodule : irq_event_unit

//--- testbench/crypto_engine_control_properties.sv
/*
 * Concurrent checks on the ports of the crypto engine control front end.
 * Assumes it is bound to crypto_engine_control and sees only its ports.
 */
`timescale 1ns/1ns
module crypto_engine_control_properties
	import crypto_engine_control_pkg::*;
#(
	parameter int OPSEL_W   = 4,
	parameter int VARIANT_W = 3
) (
	input wire logic                                clock,
	input wire logic                                nrst,
	input wire logic                                idleMode,
	input wire logic                                opDone,
	input wire logic                                inputConsumed,
	input wire logic                                counterWrap,
	input wire logic                                engineOn,
	input wire logic                                engineActive,
	input wire logic                                opStart,
	input wire logic                                opAbort,
	input wire logic [OPSEL_W-1:0]                  operationSelect,
	input wire logic                                cipherSelect,
	input wire logic [VARIANT_W-1:0]                cipherVariant,
	input wire crypto_engine_control_pkg::abort_cause_t lastAbortCause,
	input wire logic                                eventPulse
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	a_start_when_on: assert property (opStart |-> engineActive && $past(engineOn))
		else $error("start pulse without an enabled run");
	a_disable_abort: assert property (opAbort && lastAbortCause == abortDisable |-> !$past(engineOn))
		else $error("disable abort while enabled");
	a_idle_abort: assert property (opAbort && lastAbortCause == abortIdle |-> $past(idleMode))
		else $error("idle abort without idle");
	a_start_once: assert property (opStart |=> !opStart)
		else $error("start pulse longer than one cycle");
	a_done_ends: assert property (engineActive && opDone |=> !engineActive)
		else $error("run continues after done");
	a_abort_stops: assert property (opAbort |-> !engineActive && $past(engineActive))
		else $error("abort outside a run or run kept");
	a_fields_held: assert property (engineActive && $past(engineActive) |->
		$stable(operationSelect) && $stable(cipherSelect) && $stable(cipherVariant))
		else $error("operation fields changed during a run");
	a_event_cause: assert property (eventPulse |-> $past(opDone || inputConsumed || counterWrap))
		else $error("event pulse without a source");
	a_abort_once: assert property (opAbort |=> !opAbort)
		else $error("abort pulse longer than one cycle");

	c_start: cover property (opStart);
	c_idle_abort: cover property (opAbort && lastAbortCause == abortIdle);
	c_event: cover property (eventPulse);
endmodule : crypto_engine_control_properties

bind crypto_engine_control crypto_engine_control_properties #(
	.OPSEL_W  (OPSEL_W),
	.VARIANT_W(VARIANT_W)
) i_props (
	.clock(clock), .nrst(nrst), .idleMode(idleMode), .opDone(opDone),
	.inputConsumed(inputConsumed), .counterWrap(counterWrap), .engineOn(engineOn),
	.engineActive(engineActive), .opStart(opStart), .opAbort(opAbort),
	.operationSelect(operationSelect), .cipherSelect(cipherSelect),
	.cipherVariant(cipherVariant), .lastAbortCause(lastAbortCause), .eventPulse(eventPulse)
);

//--- testbench/crypto_engine_control_tb.sv
/*
 * Self-checking bench for the crypto engine control front end.
 * Assumes the register map of the params header; the bench plays both software and datapath.
 */
`timescale 1ns/1ns
`include "crypto_engine_control_params.svh"
module crypto_engine_control_tb;
	import crypto_engine_control_pkg::*;

	logic         clock         = 1'h0;
	logic         nrst          = 1'h0;
	logic [7:0]   regAddr       = 8'h00;
	logic [15:0]  regWriteData  = 16'h0000;
	logic         regWrite      = 1'h0;
	logic         regRead       = 1'h0;
	logic         idleMode      = 1'h0;
	logic         opDone        = 1'h0;
	logic         inputConsumed = 1'h0;
	logic         counterWrap   = 1'h0;
	logic [15:0]  regReadData;
	logic         engineOn, engineActive, opStart, opAbort, cipherSelect, eventPulse, irq;
	logic [3:0]   operationSelect;
	logic [2:0]   cipherVariant;
	abort_cause_t lastAbortCause;
	int           errorCnt      = 0;
	int           checked       = 0;
	int           cycles        = 0;

	crypto_engine_control i_dut (
		.clock(clock), .nrst(nrst), .regAddr(regAddr), .regWriteData(regWriteData),
		.regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .idleMode(idleMode),
		.opDone(opDone), .inputConsumed(inputConsumed), .counterWrap(counterWrap),
		.engineOn(engineOn), .engineActive(engineActive), .opStart(opStart), .opAbort(opAbort),
		.operationSelect(operationSelect), .cipherSelect(cipherSelect),
		.cipherVariant(cipherVariant), .lastAbortCause(lastAbortCause),
		.eventPulse(eventPulse), .irq(irq)
	);

	always #5 clock = ~clock;

	// The whole run needs under two hundred cycles, so this only catches a hang.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 4000) begin
			errorCnt++;
			wrapUp();
		end
	end

	////////////////////////////////////////////////////////////
	task automatic wrapUp();
		if (errorCnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrapUp

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errorCnt++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		regWrite     <= 1'h1;
		regAddr      <= a;
		regWriteData <= d;
		@(posedge clock);
		regWrite <= 1'h0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clock);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'h0;
		#1;
		chk(regReadData, e);
	endtask : rd

	task automatic pulse(input logic d, input logic c, input logic w);
		@(posedge clock);
		opDone        <= d;
		inputConsumed <= c;
		counterWrap   <= w;
		@(posedge clock);
		opDone        <= 1'h0;
		inputConsumed <= 1'h0;
		counterWrap   <= 1'h0;
		#1;
	endtask : pulse

	// Bounded wait, since a start may sit pending for a few cycles.
	task automatic waitActive(input logic e);
		int n;
		n = 0;
		while (engineActive !== e && n < 20) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk(engineActive, e);
	endtask : waitActive

	task automatic expAbort(input abort_cause_t c);
		@(posedge clock);
		#1;
		chk(opAbort, 16'h0001);
		chk(engineActive, 16'h0000);
		chk(lastAbortCause, c);
	endtask : expAbort

	////////////////////////////////////////////////////////////
	task automatic resetValues();
		for (int a = 0; a <= 32; a += 4) rd(8'(a), 16'h0000);
		wr(`CTRL_OFFSET, 16'hfeff);
		rd(`CTRL_OFFSET, 16'hbcff);
	endtask : resetValues

	task automatic startDone();
		wr(`IRQ_ENABLE_OFFSET, 16'h000f);
		wr(`CTRL_OFFSET, 16'h8950);
		waitActive(1'h1);
		chk(opStart, 16'h0001);
		chk(operationSelect, 16'h0005);
		wr(`CTRL_OFFSET, 16'h89a7);
		rd(`CTRL_OFFSET, 16'h8950);
		pulse(1'h1, 1'h0, 1'h0);
		chk(eventPulse, 16'h0001);
		chk(engineActive, 16'h0000);
		rd(`CTRL_OFFSET, 16'h8850);
		rd(`IRQ_STAT_OFFSET, 16'h0002);
		rd(`OP_COUNT_OFFSET, 16'h0001);
		rd(`LAST_CYC_OFFSET, 16'h0006);
		chk(irq, 16'h0001);
		wr(`IRQ_CLEAR_OFFSET, 16'h0002);
		chk(irq, 16'h0000);
	endtask : startDone

	task automatic eventsAndStop();
		wr(`CTRL_OFFSET, 16'h9000);
		pulse(1'h0, 1'h0, 1'h1);
		chk(eventPulse, 16'h0001);
		wr(`CTRL_OFFSET, 16'h8500);
		waitActive(1'h1);
		pulse(1'h0, 1'h1, 1'h0);
		chk(eventPulse, 16'h0001);
		pulse(1'h0, 1'h0, 1'h1);
		chk(eventPulse, 16'h0000);
		rd(`IRQ_STAT_OFFSET, 16'h0005);
		wr(`IRQ_ENABLE_OFFSET, 16'h0000);
		chk(irq, 16'h0000);
		wr(`IRQ_ENABLE_OFFSET, 16'h000f);
		chk(irq, 16'h0001);
		wr(`CTRL_OFFSET, 16'h8400);
		expAbort(abortSoftware);
		wr(`IRQ_CLEAR_OFFSET, 16'h000f);
		rd(`IRQ_STAT_OFFSET, 16'h0000);
	endtask : eventsAndStop

	task automatic idleHalt();
		wr(`CTRL_OFFSET, 16'ha100);
		waitActive(1'h1);
		@(posedge clock);
		idleMode <= 1'h1;
		expAbort(abortIdle);
		wr(`CTRL_OFFSET, 16'ha100);
		repeat (3) @(posedge clock);
		#1;
		chk(engineActive, 16'h0000);
		rd(`STATUS_OFFSET, 16'h0016);
		@(posedge clock);
		idleMode <= 1'h0;
		waitActive(1'h1);
		wr(`CTRL_OFFSET, 16'h8100);
		@(posedge clock);
		idleMode <= 1'h1;
		repeat (3) @(posedge clock);
		#1;
		chk(engineActive, 16'h0001);
		@(posedge clock);
		idleMode <= 1'h0;
	endtask : idleHalt

	task automatic disableStop();
		wr(`CTRL_OFFSET, 16'h0100);
		expAbort(abortDisable);
		chk(engineOn, 16'h0000);
	endtask : disableStop

	task automatic clearMode();
		wr(`CTRL_OFFSET, 16'h9c35);
		wr(`CTRL_OFFSET, 16'h9d3d);
		waitActive(1'h1);
		chk({operationSelect, cipherSelect, cipherVariant}, 16'h003d);
		rd(`MODE_OFFSET, 16'h0002);
		wr(`MODE_OFFSET, 16'h0001);
		expAbort(abortClearMode);
		rd(`CTRL_OFFSET, 16'h8000);
		wr(`MODE_OFFSET, 16'h0000);
	endtask : clearMode

	// A reset in mid-run must drop the run and every field, not only the power-on state.
	task automatic midReset();
		wr(`CTRL_OFFSET, 16'hbd35);
		waitActive(1'h1);
		@(posedge clock);
		nrst <= 1'h0;
		repeat (20) @(posedge clock);
		nrst <= 1'h1;
		#1;
		chk({engineOn, engineActive, operationSelect, cipherSelect, cipherVariant}, 16'h0000);
		rd(`CTRL_OFFSET, 16'h0000);
		rd(`IRQ_STAT_OFFSET, 16'h0000);
	endtask : midReset

	////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clock);
		nrst <= 1'h1;
		resetValues();
		startDone();
		eventsAndStop();
		idleHalt();
		disableStop();
		clearMode();
		midReset();
		wrapUp();
	end
endmodule : crypto_engine_control_tb
